// file: src/wwd_pkg.sv
// Package of register map, fields and counts for the windowed watchdog
package wwd_pkg;
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_COUNTER = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_MASK = 8'h10;
	localparam logic [7:0] CLEAR_KEY = 8'h5a;
	localparam int MODE_PERIOD_LSB = 0;
	localparam int MODE_WIN_BIT = 3;
	localparam int MODE_CLOSED_LSB = 16;
	localparam int CNT_W = 14;
	localparam logic [31:0] MODE_RESET = 32'h0000_0007;
	localparam int STS_IRQ_BIT = 0;
	localparam int STS_OVF_RST_BIT = 1;
	localparam int STS_INV_RST_BIT = 2;
	localparam logic [2:0] MASK_RESET = 3'h0;
	// Low speed clock 32.768 kHz over 32 gives the 1.024 kHz count tick
	localparam int LS_DIV = 32;
	localparam logic [4:0] LS_DIV_LAST = 5'(LS_DIV - 1);
	// Overflow periods in count ticks: 7.8 ms .. 8 s at 1.024 kHz
	localparam logic [CNT_W-1:0] PERIOD_TICKS [8] = '{
		14'h0008, 14'h0010, 14'h0020, 14'h0040,
		14'h0080, 14'h0200, 14'h0800, 14'h2000};
	localparam logic [1:0] STRAP_WAIT = 2'h3;
endpackage

// file: src/wwd_top.sv
// Windowed watchdog timer with AHB-Lite register slave
// Behaviour
// - No window: first overflow interrupt, second resets
// - Window mode: first overflow resets, no interrupt
// - Window mode: clear while closed gives invalid-clear reset
// - No window: clear accepted anytime, restarts interval
// - Eight overflow periods, 7.8 ms to 8 s
// - Software sets closed and open window spans
// - Run enable fixed by strap at startup
// - Count clock: low speed /32 or RC oscillator
// - Low speed source gives 1.024 kHz tick
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module wwd_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic por_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic low_speed_clock,
	input wire logic kilohertz_rc_oscillator,
	input wire logic opt_wdt_enable,
	input wire logic opt_rc_select,
	output logic wdt_irq,
	output logic wdt_overflow_reset,
	output logic wdt_invalid_clear_reset
);
	localparam int CNT_W_L = wwd_pkg::CNT_W;
	logic [2:0] ls_sync_r;
	logic [2:0] rc_sync_r;
	logic [1:0] en_sync_r;
	logic [1:0] sel_sync_r;
	logic [1:0] strap_cnt_r;
	logic run_en_r;
	logic rc_sel_r;
	logic [4:0] div_r;
	logic tick;
	logic [CNT_W_L-1:0] cnt_r;
	logic second_r;
	logic [31:0] mode_r;
	logic [2:0] mask_r;
	logic sts_irq_r;
	logic sts_ovf_r;
	logic sts_inv_r;
	logic ovf_rst_r;
	logic inv_rst_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic addr_ok;
	logic [7:0] a_off;
	logic rd_status;
	logic clr_req;
	logic win_en;
	logic [CNT_W_L-1:0] closed_ticks;
	logic [CNT_W_L-1:0] period;
	logic ovf_ev;
	logic [2:0] sts_all;

	// Pin synchronisers; only the settled stages feed edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ls_sync_r <= 3'h0;
			rc_sync_r <= 3'h0;
			en_sync_r <= 2'h0;
			sel_sync_r <= 2'h0;
		end else begin
			ls_sync_r <= {ls_sync_r[1:0], low_speed_clock};
			rc_sync_r <= {rc_sync_r[1:0], kilohertz_rc_oscillator};
			en_sync_r <= {en_sync_r[0], opt_wdt_enable};
			sel_sync_r <= {sel_sync_r[0], opt_rc_select};
		end
	end

	// Straps are caught once after release; runtime writes cannot stop the dog
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_cnt_r <= 2'h0;
			run_en_r <= 1'b0;
			rc_sel_r <= 1'b0;
		end else if (strap_cnt_r != wwd_pkg::STRAP_WAIT) begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == wwd_pkg::STRAP_WAIT - 2'h1) begin
				run_en_r <= en_sync_r[1];
				rc_sel_r <= sel_sync_r[1];
			end
		end
	end

	AST_STRAP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
		strap_cnt_r == wwd_pkg::STRAP_WAIT |=> $stable(run_en_r) && $stable(rc_sel_r))
		else $error("strap latch changed after startup");
	AST_STRAP_EARLY: assert property (@(posedge hclk) disable iff (!hresetn)
		strap_cnt_r != wwd_pkg::STRAP_WAIT |-> !run_en_r)
		else $error("watchdog ran before straps settled");

	// Count tick from the chosen source
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= 5'h0;
		end else if (ls_sync_r[1] && !ls_sync_r[2]) begin
			div_r <= div_r + 5'h1;
		end
	end
	assign tick = rc_sel_r ? (rc_sync_r[1] && !rc_sync_r[2])
		: (ls_sync_r[1] && !ls_sync_r[2] && div_r == wwd_pkg::LS_DIV_LAST);

	AST_LS_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
		ls_sync_r[1] && !ls_sync_r[2] |=> div_r == $past(div_r) + 5'h1)
		else $error("low speed divider missed an edge");
	AST_TICK_ONCE: assert property (@(posedge hclk) disable iff (!hresetn)
		tick |=> !tick)
		else $error("one source edge gave more than one tick");

	// Register bus decode
	assign a_off = haddr[7:0];
	assign addr_ok = hsel && hready && htrans[1];
	assign rd_status = addr_ok && !hwrite && a_off == wwd_pkg::ADDR_STATUS;
	assign clr_req = wr_pend_r && wr_addr_r == wwd_pkg::ADDR_CONTROL
		&& hwdata[7:0] == wwd_pkg::CLEAR_KEY;
	assign win_en = mode_r[wwd_pkg::MODE_WIN_BIT];
	assign closed_ticks = mode_r[wwd_pkg::MODE_CLOSED_LSB +: CNT_W_L];
	assign period = wwd_pkg::PERIOD_TICKS[mode_r[wwd_pkg::MODE_PERIOD_LSB +: 3]];
	// Period change mid-count may leave cnt_r above it; >= still overflows
	assign ovf_ev = run_en_r && tick && !clr_req && cnt_r >= period - 14'h1;
	assign sts_all = {sts_inv_r, sts_ovf_r, sts_irq_r};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h0;
		end else begin
			wr_pend_r <= addr_ok && hwrite;
			wr_addr_r <= a_off;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r <= wwd_pkg::MODE_RESET;
			mask_r <= wwd_pkg::MASK_RESET;
		end else if (wr_pend_r) begin
			if (wr_addr_r == wwd_pkg::ADDR_MODE) begin
				mode_r <= hwdata & 32'h3fff_000f;
			end
			if (wr_addr_r == wwd_pkg::ADDR_MASK) begin
				mask_r <= hwdata[2:0];
			end
		end
	end

	// Read data registered in the address phase, valid in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0;
		end else if (addr_ok && !hwrite) begin
			unique case (a_off)
				wwd_pkg::ADDR_CONTROL: hrdata_r <= {31'h0, run_en_r};
				wwd_pkg::ADDR_MODE: hrdata_r <= mode_r;
				wwd_pkg::ADDR_COUNTER: hrdata_r <= {18'h0, cnt_r};
				wwd_pkg::ADDR_STATUS: hrdata_r <= {29'h0, sts_all};
				wwd_pkg::ADDR_MASK: hrdata_r <= {29'h0, mask_r};
				default: hrdata_r <= 32'h0;
			endcase
		end
	end
	assign hrdata = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	AST_STS_READ: assert property (@(posedge hclk) disable iff (!hresetn || !por_n)
		rd_status |=> hrdata[2:0] == $past(sts_all))
		else $error("status read did not return the value before clearing");
	AST_MODE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_r && wr_addr_r == wwd_pkg::ADDR_MODE
		|=> closed_ticks == $past(hwdata[wwd_pkg::MODE_CLOSED_LSB +: CNT_W_L]))
		else $error("closed window span not taken from mode write");

	// Counter and overflow sequencing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 14'h0;
			second_r <= 1'b0;
		end else if (!run_en_r) begin
			cnt_r <= 14'h0;
			second_r <= 1'b0;
		end else if (clr_req) begin
			cnt_r <= 14'h0;
			second_r <= 1'b0;
		end else if (ovf_ev) begin
			cnt_r <= 14'h0;
			second_r <= !win_en && !second_r;
		end else if (tick) begin
			cnt_r <= cnt_r + 14'h1;
		end
	end

	// Clear wins over a coincident tick, so a late clear is never lost
	AST_COUNT_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
		run_en_r && tick && !clr_req && !ovf_ev |=> cnt_r == $past(cnt_r) + 14'h1)
		else $error("counter did not step on a tick");
	AST_COUNT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
		run_en_r && !tick && !clr_req |=> $stable(cnt_r))
		else $error("counter moved without a tick");
	AST_CLR_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
		run_en_r && clr_req |=> !second_r && cnt_r == 14'h0)
		else $error("clear did not restart the overflow sequence");

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovf_rst_r <= 1'b0;
			inv_rst_r <= 1'b0;
		end else begin
			ovf_rst_r <= ovf_ev && (win_en || second_r);
			inv_rst_r <= run_en_r && clr_req && win_en && cnt_r < closed_ticks;
		end
	end
	assign wdt_overflow_reset = ovf_rst_r;
	assign wdt_invalid_clear_reset = inv_rst_r;

	AST_OVF_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
		ovf_rst_r |=> !ovf_rst_r)
		else $error("overflow reset longer than one cycle");
	AST_INV_ONLY_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
		!(run_en_r && clr_req) |=> !inv_rst_r)
		else $error("invalid-clear reset without a clear");
	AST_OPEN_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
		run_en_r && clr_req && win_en && cnt_r >= closed_ticks |=> !inv_rst_r && cnt_r == 14'h0)
		else $error("clear in open window was refused");
	AST_NO_SPURIOUS_RST: assert property (@(posedge hclk) disable iff (!hresetn)
		!ovf_ev |=> !ovf_rst_r)
		else $error("overflow reset without an overflow");

	// Sticky interrupt bit; a set in the read cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sts_irq_r <= 1'b0;
		end else begin
			sts_irq_r <= (sts_irq_r && !rd_status) || (ovf_ev && !win_en && !second_r);
		end
	end

	AST_IRQ_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
		sts_irq_r && !rd_status |=> sts_irq_r)
		else $error("interrupt status lost without a read");
	AST_IRQ_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_status && !ovf_ev |=> !sts_irq_r)
		else $error("status read did not clear the interrupt bit");

	// Cause bits survive the watchdog reset itself: only power-on or a status read clears them
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			sts_ovf_r <= 1'b0;
			sts_inv_r <= 1'b0;
		end else begin
			sts_ovf_r <= (sts_ovf_r && !rd_status) || ovf_rst_r;
			sts_inv_r <= (sts_inv_r && !rd_status) || inv_rst_r;
		end
	end
	assign wdt_irq = |(sts_all & mask_r);

	AST_CAUSE_INV: assert property (@(posedge hclk) disable iff (!hresetn || !por_n)
		inv_rst_r |=> sts_inv_r)
		else $error("invalid-clear reset cause not recorded");

	AST_FIRST_OVF_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
		ovf_ev && !win_en && !second_r |=> sts_irq_r && !ovf_rst_r && second_r)
		else $error("first overflow without window did not raise interrupt");
	AST_SECOND_OVF_RST: assert property (@(posedge hclk) disable iff (!hresetn)
		ovf_ev && !win_en && second_r |=> ovf_rst_r ##1 !ovf_rst_r)
		else $error("second overflow did not give one reset pulse");
	AST_WIN_OVF_RST: assert property (@(posedge hclk) disable iff (!hresetn)
		ovf_ev && win_en |=> ovf_rst_r && !$rose(sts_irq_r))
		else $error("window overflow did not reset or touched interrupt");
	AST_INVALID_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
		run_en_r && clr_req && win_en && cnt_r < closed_ticks |=> inv_rst_r && cnt_r == 14'h0)
		else $error("clear in closed window did not give invalid-clear reset");
	AST_NOWIN_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
		run_en_r && clr_req && !win_en |=> cnt_r == 14'h0 && !inv_rst_r && !ovf_rst_r)
		else $error("clear without window was not accepted");
	AST_PERIOD: assert property (@(posedge hclk) disable iff (!hresetn)
		run_en_r && tick && !clr_req && $stable(mode_r) && cnt_r == period - 14'h1
		|=> cnt_r == 14'h0 && (ovf_rst_r || second_r))
		else $error("overflow did not occur at selected period");
	AST_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
		!run_en_r |-> cnt_r == 14'h0 && !ovf_rst_r && !inv_rst_r)
		else $error("disabled watchdog counted or reset");
	AST_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn || !por_n)
		ovf_rst_r |=> sts_ovf_r)
		else $error("overflow reset cause not recorded");
	AST_LS_TICK: assert property (@(posedge hclk) disable iff (!hresetn)
		tick && !rc_sel_r |-> div_r == 5'h1f)
		else $error("low speed tick not on every 32nd edge");
endmodule
`default_nettype wire

// file: verif/wwd_top_tb.sv
// Self-checking bench for the windowed watchdog over AHB-Lite
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module wwd_top_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic por_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic rc_clk = 1'b0;
	logic ls_clk = 1'b0;
	logic en_opt = 1'b1;
	logic rc_opt = 1'b1;
	logic hresp;
	logic [31:0] hrdata;
	logic hreadyout;
	logic wdt_irq;
	logic ovf_rst;
	logic inv_rst;
	logic [31:0] rd;
	int failures = 0;
	int total_checks = 0;
	int ovf_n = 0;
	int inv_n = 0;
	always #25 hclk = ~hclk;
	wwd_top dut_u (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.low_speed_clock(ls_clk), .kilohertz_rc_oscillator(rc_clk),
		.opt_wdt_enable(en_opt), .opt_rc_select(rc_opt), .wdt_irq(wdt_irq),
		.wdt_overflow_reset(ovf_rst), .wdt_invalid_clear_reset(inv_rst));
	always @(posedge hclk) begin
		if (ovf_rst === 1'b1)
			ovf_n++;
		if (inv_rst === 1'b1)
			inv_n++;
	end
	task give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			failures++;
			give_verdict;
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask
	// Slow pulses so the two-flop synchroniser sees every edge
	task ticks(input int n);
		repeat (rc_opt ? n : n * wwd_pkg::LS_DIV) begin
			rc_clk <= rc_opt;
			ls_clk <= !rc_opt;
			repeat (3) @(posedge hclk);
			rc_clk <= 1'b0;
			ls_clk <= 1'b0;
			repeat (3) @(posedge hclk);
		end
		repeat (6) @(posedge hclk);
	endtask
	task clr;
		xfer(1'b1, wwd_pkg::ADDR_CONTROL, {24'h0, wwd_pkg::CLEAR_KEY});
		repeat (3) @(posedge hclk);
	endtask
	// Straps change only while reset is held
	task restart(input logic en, input logic rc);
		hresetn <= 1'b0;
		en_opt <= en;
		rc_opt <= rc;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		por_n <= 1'b1;
		repeat (4) @(posedge hclk);
		xfer(1'b0, wwd_pkg::ADDR_MODE, 32'h0);
		`CHK(rd, wwd_pkg::MODE_RESET)
		xfer(1'b0, wwd_pkg::ADDR_MASK, 32'h0);
		`CHK(rd, 32'h0)
		xfer(1'b0, wwd_pkg::ADDR_CONTROL, 32'h0);
		`CHK(rd[0], 1'b1)
		xfer(1'b1, 8'h14, 32'hffff_ffff);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(rd, 32'h0)
		xfer(1'b1, wwd_pkg::ADDR_MODE, 32'h0);
		clr;
		ticks(3);
		xfer(1'b0, wwd_pkg::ADDR_COUNTER, 32'h0);
		`CHK(rd, 32'h3)
		clr;
		ticks(7);
		clr;
		ticks(7);
		xfer(1'b0, wwd_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h0)
		ticks(1);
		`CHK(wdt_irq, 1'b0)
		xfer(1'b1, wwd_pkg::ADDR_MASK, 32'h1);
		@(posedge hclk);
		`CHK(wdt_irq, 1'b1)
		xfer(1'b0, wwd_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h1)
		@(posedge hclk);
		`CHK(wdt_irq, 1'b0)
		ticks(7);
		`CHK(ovf_n, 0)
		ticks(1);
		`CHK(ovf_n, 1)
		xfer(1'b0, wwd_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h2)
		xfer(1'b1, wwd_pkg::ADDR_MODE, 32'h1);
		clr;
		ticks(15);
		xfer(1'b0, wwd_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h0)
		ticks(1);
		xfer(1'b0, wwd_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h1)
		// Window mode, closed span of four ticks after each clear
		clr;
		xfer(1'b1, wwd_pkg::ADDR_MODE, 32'h0004_0008);
		clr;
		`CHK(inv_n, 1)
		ticks(4);
		clr;
		`CHK(inv_n, 1)
		ticks(7);
		`CHK(ovf_n, 1)
		ticks(1);
		`CHK(ovf_n, 2)
		`CHK(wdt_irq, 1'b0)
		// Low speed source: 32 edges per tick
		restart(1'b1, 1'b0);
		xfer(1'b0, wwd_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h6)
		xfer(1'b1, wwd_pkg::ADDR_MODE, 32'h0);
		clr;
		`CHK(hresp, 1'b0)
		ticks(3);
		xfer(1'b0, wwd_pkg::ADDR_COUNTER, 32'h0);
		`CHK(rd, 32'h3)
		ticks(4);
		xfer(1'b0, wwd_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h0)
		ticks(1);
		xfer(1'b0, wwd_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h1)
		`CHK(ovf_n, 2)
		// Strap off: nothing counts or fires
		restart(1'b0, 1'b1);
		xfer(1'b0, wwd_pkg::ADDR_CONTROL, 32'h0);
		`CHK(rd, 32'h0)
		xfer(1'b1, wwd_pkg::ADDR_MODE, 32'h0);
		clr;
		ticks(9);
		xfer(1'b0, wwd_pkg::ADDR_COUNTER, 32'h0);
		`CHK(rd, 32'h0)
		xfer(1'b0, wwd_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h0)
		`CHK(ovf_n + inv_n, 3)
		give_verdict;
	end
endmodule
`default_nettype wire
